// ### verilog/dmc_top.sv
// dma channel control, flag clearing and a simple transfer engine shared by all channels
//
// Contract
// R1: a one in a channel error clear bit clears its error flag; zero does nothing
// R2: a one in a half-done clear bit clears that flag; zero does nothing
// R3: a one in a full-done clear bit clears that flag; zero does nothing
// R4: a one in a global clear bit clears global, error, half and full flags
// R5: channel x control register sits at 0x08 plus 0x14 times x
// R6: memory copy mode bit runs the channel without peripheral requests
// R7: memory width field selects 8, 16 or 32 bits; code 11 reserved
// R8: peripheral width field selects 8, 16 or 32 bits; code 11 reserved
// R9: memory address fixed or increasing after each transfer per its bit
// R10: peripheral address fixed or increasing after each transfer per its bit
// R11: circular bit reloads count and addresses when a pass ends
// R12: direction zero reads peripheral writes memory; one reverses it
// R13: error enable gates the error interrupt request
// R14: half-done enable gates the half-done interrupt request
// R15: full-done enable gates the full-done interrupt request
// R16: single-bit configuration fields are locked while the channel is enabled; the code leaves the three interrupt enables writable
// R17: priority and both width fields are locked while the channel is enabled
// R18: flags are set by hardware and stay set until cleared by software
// R19: a channel interrupts when any enabled event flag of it is set
// R20: in a five-channel instance the bits of channels five and six do nothing
// R21: priority codes low to ultra high; highest pending level is served first
// R22: enable starts servicing requests; clearing stops it and unlocks configuration
`timescale 1ns/100ps
`include "dmc_params.svh"

module dmc_top #(
    parameter int num_channels = `DMC_MAX_CH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [`DMC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [`DMC_MAX_CH-1:0] periph_req,
    output logic [`DMC_MAX_CH-1:0] periph_ack,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata,
    output logic bus_rd,
    output logic bus_wr,
    output logic [1:0] bus_size,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic bus_err,
    output logic [`DMC_MAX_CH-1:0] irq
);

    // {hit, register select, channel}
    function automatic logic [5:0] dmc_decode(input logic [`DMC_ADDR_W-1:0] a);
        logic [7:0] rel;
        logic [5:0] res;
        res = 6'h00;
        for (int i = 0; i < `DMC_MAX_CH; i++)
        begin
            rel = a - (`DMC_OFS_CTL0 + 8'(i) * `DMC_CH_STRIDE);
            if (rel < `DMC_OFS_CH_END && rel[1:0] == 2'h0)
                res = {1'b1, rel[3:2], 3'(i)};
        end
        return res;
    endfunction : dmc_decode
    // byte step of one transfer for a width code
    function automatic logic [31:0] dmc_step(input logic [1:0] w);
        case (dmc_pkg::dmc_width_t'(w))
            dmc_pkg::DMC_WIDTH_8: return 32'h00000001;
            dmc_pkg::DMC_WIDTH_16: return 32'h00000002;
            default: return 32'h00000004;
        endcase
    endfunction : dmc_step
    logic [`DMC_CTL_W-1:0] ctl [`DMC_MAX_CH];
    logic [`DMC_CNT_W-1:0] cnt [`DMC_MAX_CH];
    logic [`DMC_CNT_W-1:0] reload [`DMC_MAX_CH];
    logic [31:0] pa_base [`DMC_MAX_CH];
    logic [31:0] ma_base [`DMC_MAX_CH];
    logic [31:0] pa_cur [`DMC_MAX_CH];
    logic [31:0] ma_cur [`DMC_MAX_CH];
    logic [`DMC_FLG_PER_CH-1:0] flg [`DMC_MAX_CH];
    dmc_pkg::dmc_state_t st;
    logic [2:0] cur;
    logic step;
    logic err_hit;
    logic [5:0] dec;
    logic dec_hit;
    logic [1:0] dec_sel;
    logic [2:0] dec_ch;
    logic clr_wr;
    logic [`DMC_MAX_CH-1:0] ev_full;
    logic [`DMC_MAX_CH-1:0] ev_half;
    logic [`DMC_MAX_CH-1:0] ev_err;
    logic [31:0] rd_value;
    // R5 R20 channel register decode
    always_comb
    begin
        dec = dmc_decode(reg_addr);
        dec_hit = dec[5] && (int'(dec[2:0]) < num_channels);
        dec_sel = dec[4:3];
        dec_ch = dec[2:0];
        clr_wr = reg_wr && reg_addr == `DMC_OFS_CLEAR;
    end
    // completion events of the step and error events of the phase that land this cycle
    always_comb
    begin
        for (int i = 0; i < `DMC_MAX_CH; i++)
        begin
            ev_full[i] = step && cur == 3'(i) && cnt[i] == 16'h0001;
            ev_half[i] = step && cur == 3'(i) && cnt[i] - 16'h0001 == (reload[i] >> 1);
            ev_err[i] = err_hit && cur == 3'(i);
        end
    end
    // channel registers: software writes and engine updates
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int i = 0; i < `DMC_MAX_CH; i++)
            begin
                ctl[i] <= `DMC_CTL_RESET;
                cnt[i] <= `DMC_CNT_RESET;
                reload[i] <= `DMC_CNT_RESET;
                pa_base[i] <= `DMC_ADDR_RESET;
                ma_base[i] <= `DMC_ADDR_RESET;
                pa_cur[i] <= `DMC_ADDR_RESET;
                ma_cur[i] <= `DMC_ADDR_RESET;
            end
        end
        else
        begin
            for (int i = 0; i < `DMC_MAX_CH; i++)
            begin
                if (step && cur == 3'(i))
                begin
                    // R9 memory address advance
                    if (ctl[i][`DMC_CTL_MINC])
                        ma_cur[i] <= ma_cur[i] + dmc_step(ctl[i][`DMC_CTL_MEMORY_DATA_WIDTH_LO +: 2]);
                    // R10 peripheral address advance
                    if (ctl[i][`DMC_CTL_PINC])
                        pa_cur[i] <= pa_cur[i] + dmc_step(ctl[i][`DMC_CTL_PERIPHERAL_DATA_WIDTH_LO +: 2]);
                    cnt[i] <= cnt[i] - 16'h0001;
                    // R11 circular reload at pass end
                    if (cnt[i] == 16'h0001 && ctl[i][`DMC_CTL_CIRC])
                    begin
                        cnt[i] <= reload[i];
                        pa_cur[i] <= pa_base[i];
                        ma_cur[i] <= ma_base[i];
                    end
                end
                if (reg_wr && dec_hit && dec_ch == 3'(i))
                begin
                    case (dec_sel)
                        `DMC_SEL_CTL:
                        begin
                            // R16 R17 configuration locked while enabled, except enable and the three interrupt enables
                            if (ctl[i][`DMC_CTL_EN])
                                ctl[i] <= (ctl[i] & ~`DMC_CTL_OPEN_MASK) | (reg_wdata[`DMC_CTL_W-1:0] & `DMC_CTL_OPEN_MASK);
                            else
                                ctl[i] <= reg_wdata[`DMC_CTL_W-1:0];
                        end
                        `DMC_SEL_CNT:
                        begin
                            if (!ctl[i][`DMC_CTL_EN])
                            begin
                                cnt[i] <= reg_wdata[`DMC_CNT_W-1:0];
                                reload[i] <= reg_wdata[`DMC_CNT_W-1:0];
                            end
                        end
                        `DMC_SEL_PADDR:
                        begin
                            if (!ctl[i][`DMC_CTL_EN])
                            begin
                                pa_base[i] <= reg_wdata;
                                pa_cur[i] <= reg_wdata;
                            end
                        end
                        default:
                        begin
                            if (!ctl[i][`DMC_CTL_EN])
                            begin
                                ma_base[i] <= reg_wdata;
                                ma_cur[i] <= reg_wdata;
                            end
                        end
                    endcase
                end
                // R22 a bus error stops the channel
                if (ev_err[i])
                    ctl[i][`DMC_CTL_EN] <= 1'b0;
            end
        end
    end
    // R18 sticky flags, a set in the clearing cycle wins
    always_ff @(posedge clock)
    begin
        if (rst)
            for (int i = 0; i < `DMC_MAX_CH; i++)
                flg[i] <= 4'h0;
        else
        begin
            for (int i = 0; i < `DMC_MAX_CH; i++)
            begin
                logic [3:0] clr;
                logic [3:0] set;
                clr = 4'h0;
                set = {ev_err[i], ev_half[i], ev_full[i], 1'b0};
                set[`DMC_FLG_GLOBAL] = |set;
                // R1 R2 R3 per-flag clear, R4 global clear
                if (clr_wr && i < num_channels)
                begin
                    clr = reg_wdata[`DMC_FLG_PER_CH*i +: `DMC_FLG_PER_CH];
                    if (clr[`DMC_FLG_GLOBAL])
                        clr = 4'hF;
                end
                flg[i] <= (flg[i] & ~clr) | set;
            end
        end
    end
    // R13 R14 R15 R19 interrupt requests
    always_ff @(posedge clock)
    begin
        if (rst)
            irq <= '0;
        else
            for (int i = 0; i < `DMC_MAX_CH; i++)
                irq[i] <= |(flg[i][`DMC_FLG_ERR:`DMC_FLG_FULL] & ctl[i][`DMC_CTL_ERROR_IRQ_ENABLE:`DMC_CTL_FULLIE]);
    end
    // read data mux
    always_comb
    begin
        rd_value = 32'h00000000;
        if (reg_addr == `DMC_OFS_FLAG)
            for (int i = 0; i < `DMC_MAX_CH; i++)
                rd_value[`DMC_FLG_PER_CH*i +: `DMC_FLG_PER_CH] = flg[i];
        else if (dec_hit)
            case (dec_sel)
                `DMC_SEL_CTL: rd_value = {17'h00000, ctl[dec_ch]};
                `DMC_SEL_CNT: rd_value = {16'h0000, cnt[dec_ch]};
                `DMC_SEL_PADDR: rd_value = pa_base[dec_ch];
                default: rd_value = ma_base[dec_ch];
            endcase
    end
    always_ff @(posedge clock)
    begin
        if (rst)
            reg_rdata <= 32'h00000000;
        else
            reg_rdata <= reg_rd ? rd_value : 32'h00000000;
    end
    // transfer engine: pick, read source, write destination, settle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= dmc_pkg::DMC_ST_IDLE;
            cur <= 3'h0;
            step <= 1'b0;
            err_hit <= 1'b0;
            bus_addr <= 32'h00000000;
            bus_wdata <= 32'h00000000;
            bus_rd <= 1'b0;
            bus_wr <= 1'b0;
            bus_size <= 2'h0;
            periph_ack <= '0;
        end
        else
        begin
            step <= 1'b0;
            err_hit <= 1'b0;
            periph_ack <= '0;
            case (st)
                dmc_pkg::DMC_ST_IDLE:
                begin
                    logic found;
                    logic [2:0] pick;
                    logic [1:0] best;
                    found = 1'b0;
                    pick = 3'h0;
                    best = 2'h0;
                    // R21 highest level first, lowest channel on a tie
                    for (int i = `DMC_MAX_CH - 1; i >= 0; i--)
                    begin
                        // R6 R22 enabled channel with a request or in copy mode
                        if (i < num_channels && ctl[i][`DMC_CTL_EN] && cnt[i] != `DMC_CNT_RESET &&
                            (ctl[i][`DMC_CTL_M2M] || periph_req[i]) &&
                            (!found || ctl[i][`DMC_CTL_CHANNEL_PRIORITY_LO +: 2] >= best))
                        begin
                            found = 1'b1;
                            pick = 3'(i);
                            best = ctl[i][`DMC_CTL_CHANNEL_PRIORITY_LO +: 2];
                        end
                    end
                    if (found)
                    begin
                        cur <= pick;
                        bus_rd <= 1'b1;
                        // R12 R7 R8 source side and its width
                        if (ctl[pick][`DMC_CTL_DIR])
                        begin
                            bus_addr <= ma_cur[pick];
                            bus_size <= ctl[pick][`DMC_CTL_MEMORY_DATA_WIDTH_LO +: 2];
                        end
                        else
                        begin
                            bus_addr <= pa_cur[pick];
                            bus_size <= ctl[pick][`DMC_CTL_PERIPHERAL_DATA_WIDTH_LO +: 2];
                        end
                        st <= dmc_pkg::DMC_ST_READ;
                    end
                end
                dmc_pkg::DMC_ST_READ:
                begin
                    if (bus_ack)
                    begin
                        bus_rd <= 1'b0;
                        if (bus_err)
                        begin
                            err_hit <= 1'b1;
                            st <= dmc_pkg::DMC_ST_DONE;
                        end
                        else
                        begin
                            bus_wr <= 1'b1;
                            bus_wdata <= bus_rdata;
                            // R12 R7 R8 destination side and its width
                            if (ctl[cur][`DMC_CTL_DIR])
                            begin
                                bus_addr <= pa_cur[cur];
                                bus_size <= ctl[cur][`DMC_CTL_PERIPHERAL_DATA_WIDTH_LO +: 2];
                            end
                            else
                            begin
                                bus_addr <= ma_cur[cur];
                                bus_size <= ctl[cur][`DMC_CTL_MEMORY_DATA_WIDTH_LO +: 2];
                            end
                            st <= dmc_pkg::DMC_ST_WRITE;
                        end
                    end
                end
                dmc_pkg::DMC_ST_WRITE:
                begin
                    if (bus_ack)
                    begin
                        bus_wr <= 1'b0;
                        if (bus_err)
                            err_hit <= 1'b1;
                        else
                        begin
                            step <= 1'b1;
                            periph_ack[cur] <= !ctl[cur][`DMC_CTL_M2M];
                        end
                        st <= dmc_pkg::DMC_ST_DONE;
                    end
                end
                // lets counter and pointer updates land before the next pick
                dmc_pkg::DMC_ST_DONE:
                    st <= dmc_pkg::DMC_ST_IDLE;
                default:
                    st <= dmc_pkg::DMC_ST_IDLE;
            endcase
        end
    end

endmodule : dmc_top

// ### shared/dmc_params.svh
// register map, field positions and reset values of the dma channel block
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

`define DMC_MAX_CH 7
`define DMC_ADDR_W 8
`define DMC_OFS_FLAG 8'h00
`define DMC_OFS_CLEAR 8'h04
`define DMC_OFS_CTL0 8'h08
`define DMC_CH_STRIDE 8'h14
`define DMC_OFS_CH_END 8'h10

`define DMC_SEL_CTL 2'h0
`define DMC_SEL_CNT 2'h1
`define DMC_SEL_PADDR 2'h2
`define DMC_SEL_MADDR 2'h3

`define DMC_FLG_GLOBAL 0
`define DMC_FLG_FULL 1
`define DMC_FLG_HALF 2
`define DMC_FLG_ERR 3
`define DMC_FLG_PER_CH 4

`define DMC_CTL_W 15
`define DMC_CTL_RESET 15'h0000
`define DMC_CTL_OPEN_MASK 15'h000F
`define DMC_CTL_M2M 14
`define DMC_CTL_CHANNEL_PRIORITY_LO 12
`define DMC_CTL_MEMORY_DATA_WIDTH_LO 10
`define DMC_CTL_PERIPHERAL_DATA_WIDTH_LO 8
`define DMC_CTL_MINC 7
`define DMC_CTL_PINC 6
`define DMC_CTL_CIRC 5
`define DMC_CTL_DIR 4
`define DMC_CTL_ERROR_IRQ_ENABLE 3
`define DMC_CTL_HALFIE 2
`define DMC_CTL_FULLIE 1
`define DMC_CTL_EN 0

`define DMC_CNT_W 16
`define DMC_CNT_RESET 16'h0000
`define DMC_ADDR_RESET 32'h00000000

`endif

// ### shared/dmc_pkg.sv
// types shared by the dma channel block
package dmc_pkg;

    typedef enum logic [1:0] {
        DMC_WIDTH_8 = 2'h0,
        DMC_WIDTH_16 = 2'h1,
        DMC_WIDTH_32 = 2'h2,
        DMC_WIDTH_RSVD = 2'h3
    } dmc_width_t;

    typedef enum logic [1:0] {
        DMC_CHANNEL_PRIORITY_LOW = 2'h0,
        DMC_CHANNEL_PRIORITY_MEDIUM = 2'h1,
        DMC_CHANNEL_PRIORITY_HIGH = 2'h2,
        DMC_CHANNEL_PRIORITY_ULTRA = 2'h3
    } dmc_channel_priority_t;

    typedef enum {
        DMC_ST_IDLE,
        DMC_ST_READ,
        DMC_ST_WRITE,
        DMC_ST_DONE
    } dmc_state_t;

endpackage : dmc_pkg

// ### bench/dmc_mem_model.sv
// system bus memory with variable latency and a fault on every ack while err_arm is high
`timescale 1ns/100ps
module dmc_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [1:0] delay,
    input wire logic err_arm,
    output logic [31:0] bus_rdata,
    output logic bus_ack,
    output logic bus_err
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] noise = 32'h0;
    int waited = 0;
    initial
    begin
        bus_rdata = 32'h0;
        bus_ack = 1'b0;
        bus_err = 1'b0;
    end
    // read data is noise except in the ack cycle of a read
    always @(posedge clock)
    begin
        noise <= noise + 32'h9E3779B9;
        bus_ack <= 1'b0;
        bus_err <= 1'b0;
        bus_rdata <= noise;
        if (rst)
            waited = 0;
        else if ((bus_rd || bus_wr) && !bus_ack)
        begin
            if (waited < delay)
                waited++;
            else
            begin
                waited = 0;
                bus_ack <= 1'b1;
                bus_err <= err_arm;
                if (bus_rd)
                    bus_rdata <= mem.exists(bus_addr) ? mem[bus_addr] : ~bus_addr;
                else
                    mem[bus_addr] = bus_wdata;
            end
        end
    end
endmodule : dmc_mem_model

// ### bench/dmc_check_properties.sv
// port relations of the dma channel block
`timescale 1ns/100ps
`include "dmc_params.svh"
module dmc_check #(
    parameter int num_channels = `DMC_MAX_CH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [`DMC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [`DMC_MAX_CH-1:0] periph_ack,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic bus_err,
    input wire logic [`DMC_MAX_CH-1:0] irq
);
    localparam logic [7:0] end_ofs = 8'(8'h04 + 8'h14 * num_channels);
    logic [31:0] held;
    logic [3:0] quiet;
    logic [3:0] since;
    logic wr_done;
    logic irq_any;
    assign wr_done = bus_wr & bus_ack;
    assign irq_any = |irq;
    always_ff @(posedge clock)
    begin
        if (bus_rd && bus_ack)
            held <= bus_rdata;
    end
    // cycles since the last bus ack, saturating
    always_ff @(posedge clock)
    begin
        if (rst || bus_ack)
            quiet <= 4'h0;
        else if (quiet != 4'hF)
            quiet <= quiet + 4'h1;
    end
    // cycles since the last ack or register write
    always_ff @(posedge clock)
    begin
        if (rst || bus_ack || reg_wr)
            since <= 4'h0;
        else if (since != 4'hF)
            since <= since + 4'h1;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
        else $error("read data outside its cycle");
    a_clear_zero: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 32'h0)
        else $error("clear register read not zero");
    a_unmapped_zero: assert property (reg_rd && reg_addr >= end_ofs |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_global_clear: assert property (reg_wr && reg_addr == 8'h04 && reg_wdata[0] && quiet >= 4'h8 |-> ##2 !irq[0])
        else $error("irq stays after global clear");
    a_write_data: assert property ($rose(bus_wr) |-> bus_wdata == held)
        else $error("write data differs from read data");
    a_rd_then_wr: assert property (bus_rd && bus_ack && !bus_err |=> bus_wr && !bus_rd)
        else $error("no write phase after read");
    a_ack_source: assert property (periph_ack != 7'h00 |-> $onehot(periph_ack) && $past(wr_done))
        else $error("request ack without write completion");
    a_irq_cause: assert property ($rose(irq_any) |-> since <= 4'h6)
        else $error("irq rose without cause");
    c_error: cover property (bus_ack && bus_err);
    c_ack: cover property (periph_ack != 7'h00);
    c_irq: cover property ($rose(irq_any));
endmodule : dmc_check
bind dmc_top dmc_check #(.num_channels(num_channels)) dmc_check_i (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .periph_ack(periph_ack), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err), .irq(irq));

// ### bench/dmc_top_test.sv
// self-checking bench for the dma channel block
`timescale 1ns/100ps
`include "dmc_params.svh"
module dmc_top_test;
    typedef struct {logic [31:0] a; logic [31:0] d; logic [2:0] k;} dmc_ph_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [`DMC_ADDR_W-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [`DMC_MAX_CH-1:0] periph_req = 7'h00;
    logic [1:0] delay = 2'h0;
    logic err_arm = 1'b0;
    logic [31:0] reg_rdata, bus_addr, bus_wdata, bus_rdata, v;
    logic [`DMC_MAX_CH-1:0] periph_ack, irq;
    logic bus_rd, bus_wr, bus_ack, bus_err;
    logic [1:0] bus_size;
    dmc_ph_t exp_q[$], got_q[$];
    int pend[7], acks[7];
    int n_fail = 0;
    int samples_checked = 0;
    always #12.5 clock = ~clock;
    dmc_top #(.num_channels(7)) dmc_top_i (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .periph_ack(periph_ack),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_size(bus_size),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err), .irq(irq));
    dmc_mem_model dmc_mem_model_i (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .delay(delay), .err_arm(err_arm), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .bus_err(bus_err));
    // records bus phases; requests held until acked
    always @(posedge clock)
    begin
        if (bus_ack === 1'b1)
            got_q.push_back('{bus_addr, bus_wr ? bus_wdata : 32'h0, {bus_wr, bus_size}});
        for (int c = 0; c < 7; c++)
        begin
            if (periph_ack[c] === 1'b1)
            begin
                pend[c]--;
                acks[c]++;
            end
            periph_req[c] <= pend[c] > 0;
        end
    end
    function automatic logic [7:0] ofs(input int c, input int k);
        return 8'(8'h08 + 8'h14 * c + 4 * k);
    endfunction : ofs
    task chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [31:0] want, input string what);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(what, reg_rdata, want);
    endtask : rd_chk
    task setup(input int c, input logic [31:0] n, input logic [31:0] p, input logic [31:0] m, input logic [31:0] ctl);
        wr(ofs(c, 1), n);
        wr(ofs(c, 2), p);
        wr(ofs(c, 3), m);
        wr(ofs(c, 0), ctl);
    endtask : setup
    task exp_xfer(input int n, input logic [31:0] s, input int ss, input logic [1:0] zs, input logic [31:0] d,
        input int ds, input logic [1:0] zd);
        for (int k = 0; k < n; k++)
        begin
            exp_q.push_back('{s + ss * k, 32'h0, {1'b0, zs}});
            exp_q.push_back('{d + ds * k, ~(s + ss * k), {1'b1, zd}});
        end
    endtask : exp_xfer
    task cmp_ph;
        int i;
        i = 0;
        while (got_q.size() < exp_q.size() && i < 3000)
        begin
            @(posedge clock);
            i++;
        end
        chk("phase count", got_q.size() >= exp_q.size(), 32'h1);
        for (int j = 0; j < exp_q.size() && j < got_q.size(); j++)
        begin
            chk("phase addr", got_q[j].a, exp_q[j].a);
            chk("phase data", got_q[j].d, exp_q[j].d);
            chk("phase kind", got_q[j].k, exp_q[j].k);
        end
        exp_q.delete();
        got_q.delete();
    endtask : cmp_ph
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        #500000;
        n_fail++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'hC23D3162));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (int c = 0; c < 7; c++)
            for (int k = 0; k < 4; k++)
                rd_chk(ofs(c, k), 32'h0, "reset value");
        rd_chk(8'h04, 32'h0, "clear reg");
        rd_chk(8'h90, 32'h0, "unmapped");
        for (int c = 0; c < 7; c++)
        begin
            v = $urandom & 32'h7FFE;
            wr(ofs(c, 0), v | 32'hFFFF8000);
            rd_chk(ofs(c, 0), v, "ctl");
            wr(ofs(c, 0), 32'h0);
        end
        wr(ofs(2, 0), 32'h2A51);
        wr(ofs(2, 0), 32'h55AF);
        rd_chk(ofs(2, 0), 32'h2A5F, "locked ctl");
        wr(ofs(2, 0), 32'h0);
        rd_chk(ofs(2, 0), 32'h2A50, "ctl on disable");
        wr(ofs(2, 0), 32'h55A0);
        rd_chk(ofs(2, 0), 32'h55A0, "unlocked ctl");
        wr(ofs(2, 0), 32'h0);
        $display("test map and lock done");
        delay <= 2'($urandom % 4);
        setup(1, 4, 32'h40001000, 32'h20000000, 32'h987);
        exp_xfer(4, 32'h40001000, 0, 2'h1, 32'h20000000, 4, 2'h2);
        pend[1] = 4;
        cmp_ph();
        repeat (8) @(posedge clock);
        chk("acks", acks[1], 32'h4);
        rd_chk(8'h00, 32'h70, "flags");
        chk("irq", irq, 32'h2);
        wr(8'h04, 32'h0);
        rd_chk(8'h00, 32'h70, "zero clear");
        wr(8'h04, 32'h40);
        rd_chk(8'h00, 32'h30, "half clear");
        chk("irq", irq, 32'h2);
        wr(8'h04, 32'h20);
        rd_chk(8'h00, 32'h10, "full clear");
        chk("irq", irq, 32'h0);
        wr(8'h04, 32'h10);
        rd_chk(8'h00, 32'h0, "global clear");
        $display("test peripheral transfer done");
        err_arm <= 1'b1;
        setup(3, 2, 32'h40002000, 32'h20002000, 32'h9);
        exp_q.push_back('{32'h40002000, 32'h0, 3'h0});
        pend[3] = 1;
        cmp_ph();
        err_arm <= 1'b0;
        pend[3] = 0;
        repeat (8) @(posedge clock);
        rd_chk(ofs(3, 0), 32'h8, "ctl after error");
        rd_chk(8'h00, 32'h9000, "flags");
        chk("irq", irq, 32'h8);
        wr(8'h04, 32'h8000);
        rd_chk(8'h00, 32'h1000, "error clear");
        wr(8'h04, 32'h1000);
        rd_chk(8'h00, 32'h0, "global clear");
        chk("irq", irq, 32'h0);
        $display("test bus error done");
        delay <= 2'($urandom % 4);
        setup(0, 2, 32'h40008000, 32'h20008000, 32'h44F1);
        exp_xfer(2, 32'h20008000, 2, 2'h1, 32'h40008000, 1, 2'h0);
        exp_xfer(2, 32'h20008000, 2, 2'h1, 32'h40008000, 1, 2'h0);
        cmp_ph();
        wr(ofs(0, 0), 32'h0);
        repeat (12) @(posedge clock);
        got_q.delete();
        chk("acks", acks[0], 32'h0);
        rd_chk(8'h00, 32'h7, "flags");
        wr(8'h04, 32'h1);
        rd_chk(8'h00, 32'h0, "global clear");
        $display("test memory copy done");
        setup(4, 2, 32'h40004000, 32'h20004000, 32'h81);
        setup(5, 2, 32'h40003000, 32'h20005000, 32'h3081);
        exp_xfer(2, 32'h40003000, 0, 2'h0, 32'h20005000, 1, 2'h0);
        exp_xfer(2, 32'h40004000, 0, 2'h0, 32'h20004000, 1, 2'h0);
        pend[4] = 2;
        pend[5] = 2;
        cmp_ph();
        repeat (8) @(posedge clock);
        rd_chk(8'h00, 32'h770000, "flags");
        chk("irq", irq, 32'h0);
        wr(ofs(5, 0), 32'h3083);
        rd_chk(ofs(5, 0), 32'h3083, "ctl enables");
        chk("irq", irq, 32'h20);
        wr(8'h04, 32'h0FFFFFFF);
        rd_chk(8'h00, 32'h0, "clear all");
        $display("test priority done");
        wrap_up();
    end
endmodule : dmc_top_test
